// ### ssx_exec.sv
`timescale 1ns/100ps
// Overview of operation
// - Post-increment store writes the source register at the pointer, then adds one; 2 cycles.
// - Pre-decrement store subtracts one from the pointer, then writes there; 2 cycles.
// - Offset store writes at Y or Z plus displacement, pointer unchanged; 2 cycles.
// - Absolute store writes at the address constant of the instruction; 2 cycles.
// - Code read loads the byte at Z into the destination register given by i_dest_reg, optional Z+1; 3 cycles.
// - Push places the source register on the stack; 2 cycles.
// - Pop takes the stack top into the destination register; 2 cycles.
module ssx_exec
  import ssx_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Decoded instruction
  input wire logic i_start,
  input wire logic [3:0] i_op,
  input wire logic [1:0] i_ptr_sel,
  input wire logic [4:0] i_source_reg,
  input wire logic [4:0] i_dest_reg,
  input wire logic [5:0] i_disp,
  input wire logic [15:0] i_abs_addr,
  input wire logic [7:0] i_sreg_in,
  // Data memory
  output logic [15:0] o_dmem_addr,
  output logic [7:0] o_dmem_wdata,
  output logic o_dmem_we,
  output logic o_dmem_re,
  input wire logic [7:0] i_dmem_rdata,
  // Program memory (byte address)
  output logic [15:0] o_pmem_addr,
  output logic o_pmem_re,
  input wire logic [7:0] i_pmem_rdata,
  // Core state
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_x,
  output logic [15:0] o_y,
  output logic [15:0] o_z,
  output logic [15:0] o_sp,
  output logic [7:0] o_sreg
);

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSX_ST_IDLE = 2'b00,
    SSX_ST_EXEC = 2'b01,
    SSX_ST_WAIT = 2'b10
  } ssx_state_e;

  ssx_state_e state_ff;
  ssx_op_e op_ff;
  logic [1:0] ptr_sel_ff;
  logic [4:0] dst_ff;
  logic [5:0] disp_ff;
  logic [15:0] abs_ff;
  logic [1:0] cnt_ff;
  logic [15:0] x_ff;
  logic [15:0] y_ff;
  logic [15:0] z_ff;
  logic [15:0] sp_ff;
  logic [7:0] sreg_ff;
  logic [15:0] ptr_val;
  logic [15:0] nxt_ptr;
  logic [15:0] nxt_addr;
  logic [7:0] src_data;
  logic rf_we;
  logic [7:0] rf_wdata;
  logic [1:0] total_cyc;

  function automatic logic [15:0] ssx_step(input logic [15:0] v, input logic up);
    ssx_step = up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction

  function automatic logic is_store(input ssx_op_e o);
    is_store = (o == SSX_OP_WR_PLAIN) || (o == SSX_OP_WR_POST) || (o == SSX_OP_WR_PRE) ||
               (o == SSX_OP_WR_OFS) || (o == SSX_OP_WR_ABS);
  endfunction

  ssx_regfile u_rf (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_we(rf_we),
    .i_waddr(dst_ff),
    .i_wdata(rf_wdata),
    .i_raddr(i_source_reg),
    .o_rdata(src_data)
  );

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ptr_sel_ff)
      SSX_PTR_X: ptr_val = x_ff;
      SSX_PTR_Y: ptr_val = y_ff;
      default: ptr_val = z_ff;
    endcase
  end

  always_comb begin
    nxt_ptr = ptr_val;
    nxt_addr = ptr_val;
    unique case (op_ff)
      SSX_OP_WR_POST: nxt_ptr = ssx_step(ptr_val, 1'b1);
      SSX_OP_WR_PRE: begin
        nxt_ptr = ssx_step(ptr_val, 1'b0);
        nxt_addr = nxt_ptr;
      end
      SSX_OP_WR_OFS: nxt_addr = 16'(ptr_val + {10'h000, disp_ff});
      SSX_OP_WR_ABS: nxt_addr = abs_ff;
      SSX_OP_PUSH: nxt_addr = sp_ff;
      SSX_OP_POP: nxt_addr = ssx_step(sp_ff, 1'b1);
      SSX_OP_CODE_INC: nxt_ptr = ssx_step(z_ff, 1'b1);
      default: nxt_ptr = ptr_val;
    endcase
  end

  always_comb begin
    unique case (op_ff)
      SSX_OP_CODE_RD, SSX_OP_CODE_INC: total_cyc = SSX_CYC_CODE;
      SSX_OP_PUSH, SSX_OP_POP: total_cyc = SSX_CYC_STACK;
      default: total_cyc = SSX_CYC_STORE;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= SSX_ST_IDLE;
      cnt_ff <= 2'h0;
      op_ff <= SSX_OP_NONE;
      ptr_sel_ff <= 2'h0;
      dst_ff <= 5'h00;
      disp_ff <= 6'h00;
      abs_ff <= 16'h0000;
    end else if (i_ce) begin
      unique case (state_ff)
        SSX_ST_IDLE: begin
          if (i_start) begin
            state_ff <= SSX_ST_EXEC;
            cnt_ff <= 2'h1;
            op_ff <= ssx_op_e'(i_op);
            ptr_sel_ff <= (i_op == SSX_OP_CODE_RD || i_op == SSX_OP_CODE_INC) ?
                          SSX_PTR_Z : i_ptr_sel;
            dst_ff <= i_dest_reg;
            disp_ff <= i_disp;
            abs_ff <= i_abs_addr;
          end
        end
        SSX_ST_EXEC: begin
          cnt_ff <= 2'(cnt_ff + 2'h1);
          state_ff <= (2'(cnt_ff + 2'h1) >= total_cyc) ? SSX_ST_WAIT : SSX_ST_EXEC;
        end
        SSX_ST_WAIT: begin
          state_ff <= SSX_ST_IDLE;
          cnt_ff <= 2'h0;
        end
        default: state_ff <= SSX_ST_IDLE;
      endcase
    end
  end

  // Data memory strobes fire in the last cycle, once the source register is read; the program read strobe fires in the second.
  logic last_cyc;
  assign last_cyc = (state_ff == SSX_ST_EXEC) && (2'(cnt_ff + 2'h1) >= total_cyc);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_dmem_addr <= 16'h0000;
      o_dmem_wdata <= 8'h00;
      o_dmem_we <= 1'b0;
      o_dmem_re <= 1'b0;
      o_pmem_addr <= 16'h0000;
      o_pmem_re <= 1'b0;
    end else if (i_ce) begin
      o_dmem_we <= last_cyc && (is_store(op_ff) || op_ff == SSX_OP_PUSH);
      o_dmem_re <= (state_ff == SSX_ST_EXEC) && (cnt_ff == 2'h1) && op_ff == SSX_OP_POP;
      o_dmem_addr <= nxt_addr;
      o_dmem_wdata <= src_data;
      o_pmem_re <= (state_ff == SSX_ST_EXEC) && (cnt_ff == 2'h1) &&
                   (op_ff == SSX_OP_CODE_RD || op_ff == SSX_OP_CODE_INC);
      o_pmem_addr <= z_ff;
    end
  end

  // Register file write from code or stack read, on the completing cycle.
  always_comb begin
    rf_we = 1'b0;
    rf_wdata = i_dmem_rdata;
    if (state_ff == SSX_ST_WAIT) begin
      if (op_ff == SSX_OP_POP) begin
        rf_we = 1'b1;
      end else if (op_ff == SSX_OP_CODE_RD || op_ff == SSX_OP_CODE_INC) begin
        rf_we = 1'b1;
        rf_wdata = i_pmem_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointer and stack pointer updates
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      x_ff <= SSX_PTR_RST;
      y_ff <= SSX_PTR_RST;
      z_ff <= SSX_PTR_RST;
      sp_ff <= SSX_SP_RST;
    end else if (i_ce && last_cyc) begin
      if (op_ff == SSX_OP_WR_POST || op_ff == SSX_OP_WR_PRE || op_ff == SSX_OP_CODE_INC) begin
        unique case (ptr_sel_ff)
          SSX_PTR_X: x_ff <= nxt_ptr;
          SSX_PTR_Y: y_ff <= nxt_ptr;
          default: z_ff <= nxt_ptr;
        endcase
      end
      if (op_ff == SSX_OP_PUSH) begin
        sp_ff <= ssx_step(sp_ff, 1'b0);
      end else if (op_ff == SSX_OP_POP) begin
        sp_ff <= ssx_step(sp_ff, 1'b1);
      end
    end
  end

  // flags only follow the core's own input
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sreg_ff <= SSX_SREG_RST;
    end else if (i_ce && state_ff == SSX_ST_IDLE) begin
      sreg_ff <= i_sreg_in;
    end
  end

  assign o_busy = (state_ff != SSX_ST_IDLE);
  assign o_done = (state_ff == SSX_ST_WAIT);
  assign o_x = x_ff;
  assign o_y = y_ff;
  assign o_z = z_ff;
  assign o_sp = sp_ff;
  assign o_sreg = sreg_ff;

endmodule // ssx_exec

// ### ssx_pkg.sv
package ssx_pkg;

  // ----------------------------------------------------------------
  // Operation codes presented by the core's decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SSX_OP_NONE     = 4'h0,
    SSX_OP_WR_PLAIN = 4'h1,
    SSX_OP_WR_POST  = 4'h2,
    SSX_OP_WR_PRE   = 4'h3,
    SSX_OP_WR_OFS   = 4'h4,
    SSX_OP_WR_ABS   = 4'h5,
    SSX_OP_CODE_RD  = 4'h6,
    SSX_OP_CODE_INC = 4'h7,
    SSX_OP_PUSH     = 4'h8,
    SSX_OP_POP      = 4'h9
  } ssx_op_e;

  // ----------------------------------------------------------------
  // Pointer selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSX_PTR_X = 2'h0,
    SSX_PTR_Y = 2'h1,
    SSX_PTR_Z = 2'h2
  } ssx_ptr_e;

  // ----------------------------------------------------------------
  // Sizes, reset values and cycle counts
  // ----------------------------------------------------------------
  localparam int SSX_NREG = 32;
  localparam logic [15:0] SSX_SP_RST = 16'h02FF;
  localparam logic [15:0] SSX_PTR_RST = 16'h0000;
  localparam logic [7:0] SSX_SREG_RST = 8'h00;
  localparam logic [1:0] SSX_CYC_STORE = 2'h2;
  localparam logic [1:0] SSX_CYC_CODE = 2'h3;
  localparam logic [1:0] SSX_CYC_STACK = 2'h2;
  localparam logic [4:0] SSX_IDX_RES_LOW = 5'h00;
  localparam logic [4:0] SSX_IDX_X = 5'h1A;
  localparam logic [4:0] SSX_IDX_Y = 5'h1C;
  localparam logic [4:0] SSX_IDX_Z = 5'h1E;

endpackage : ssx_pkg

// ### ssx_regfile.sv
`timescale 1ns/100ps
module ssx_regfile
  import ssx_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Write port
  input wire logic i_we,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Registered read port
  input wire logic [4:0] i_raddr,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_ff [SSX_NREG];

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= mem_ff[i_raddr];
    end
  end

endmodule // ssx_regfile

// ### ssx_exec_asserts.sv
`timescale 1ns/100ps
module ssx_exec_asserts
  import ssx_pkg::*;
(
  // Watched ports
  input wire logic i_clk, i_sys_rst, i_ce, i_start, o_dmem_we, o_done, o_busy,
  input wire logic [3:0] i_op,
  input wire logic [1:0] i_ptr_sel,
  input wire logic [5:0] i_disp,
  input wire logic [15:0] i_abs_addr, o_dmem_addr, o_x, o_y, o_z, o_sp,
  input wire logic [7:0] o_sreg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic take;
  assign take = i_ce && i_start && !o_busy;
  a_short_op_len: assert property (take && i_op inside {[1:5], 8, 9}
    |=> !o_done ##1 o_done) else $error("short op length wrong");
  a_code_rd_len: assert property (take && i_op inside {6, 7}
    |=> !o_done [*2] ##1 o_done) else $error("code read length wrong");
  a_post_inc_x: assert property (take && i_op == 4'h2 && i_ptr_sel == 2'h0 |-> ##2
    (o_dmem_we && o_dmem_addr == $past(o_x, 2) && o_x == $past(o_x, 2) + 16'h0001))
    else $error("post increment wrong");
  a_pre_dec_y: assert property (take && i_op == 4'h3 && i_ptr_sel == 2'h1 |-> ##2
    (o_dmem_we && o_y == $past(o_y, 2) - 16'h0001 && o_dmem_addr == o_y))
    else $error("pre decrement wrong");
  a_offset_z: assert property (take && i_op == 4'h4 && i_ptr_sel == 2'h2 |-> ##2
    (o_dmem_we && o_z == $past(o_z, 2) && o_dmem_addr == o_z + {10'h000, $past(i_disp, 2)}))
    else $error("offset store wrong");
  a_abs_store: assert property (take && i_op == 4'h5 |-> ##2
    (o_dmem_we && o_dmem_addr == $past(i_abs_addr, 2))) else $error("absolute store wrong");
  a_push_sp: assert property (take && i_op == 4'h8 |-> ##2
    (o_dmem_we && o_dmem_addr == $past(o_sp, 2) && o_sp == $past(o_sp, 2) - 16'h0001))
    else $error("push wrong");
  a_pop_sp: assert property (take && i_op == 4'h9 |-> ##2
    (o_sp == $past(o_sp, 2) + 16'h0001)) else $error("pop wrong");
  a_flags_held: assert property (o_busy |=> $stable(o_sreg))
    else $error("flags changed while busy");
endmodule // ssx_exec_asserts
bind ssx_exec ssx_exec_asserts i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
  .i_start(i_start), .o_dmem_we(o_dmem_we), .o_done(o_done), .o_busy(o_busy), .i_op(i_op),
  .i_ptr_sel(i_ptr_sel), .i_disp(i_disp), .i_abs_addr(i_abs_addr), .o_dmem_addr(o_dmem_addr),
  .o_x(o_x), .o_y(o_y), .o_z(o_z), .o_sp(o_sp), .o_sreg(o_sreg));

// ### ssx_mem_model.sv
`timescale 1ns/100ps
module ssx_mem_model (
  // Memory ports
  input wire logic i_clk, i_dmem_we, i_dmem_re, i_pmem_re,
  input wire logic [15:0] i_dmem_addr, i_pmem_addr,
  input wire logic [7:0] i_dmem_wdata,
  output logic [7:0] o_dmem_rdata, o_pmem_rdata
);
  logic [7:0] mem [256];
  logic [15:0] last_addr = 16'h0000, rd_addr = 16'h0000, pm_addr = 16'h0000;
  logic [7:0] last_data = 8'h00;
  logic [1:0] d_hold = 2'h0, p_hold = 2'h0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  // Read data only holds for a short window, then scrambles to expose late sampling.
  assign o_dmem_rdata = i_dmem_re ? mem[i_dmem_addr[7:0]] :
    (d_hold != 2'h0 ? mem[rd_addr[7:0]] : ~mem[rd_addr[7:0]]);
  assign o_pmem_rdata = i_pmem_re ? ~i_pmem_addr[7:0] :
    (p_hold != 2'h0 ? ~pm_addr[7:0] : pm_addr[7:0]);
  always @(posedge i_clk) begin
    d_hold <= i_dmem_re ? 2'h2 : (d_hold != 2'h0 ? d_hold - 2'h1 : 2'h0);
    p_hold <= i_pmem_re ? 2'h2 : (p_hold != 2'h0 ? p_hold - 2'h1 : 2'h0);
    if (i_dmem_re) rd_addr <= i_dmem_addr;
    if (i_pmem_re) pm_addr <= i_pmem_addr;
    if (i_dmem_we) begin
      mem[i_dmem_addr[7:0]] <= i_dmem_wdata;
      last_addr <= i_dmem_addr;
      last_data <= i_dmem_wdata;
    end
  end
endmodule // ssx_mem_model

// ### tb.sv
`timescale 1ns/100ps
module tb;
  import ssx_pkg::*;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_start = 1'b0;
  logic [3:0] i_op = 4'h0;
  logic [1:0] i_ptr_sel = 2'h0;
  logic [4:0] i_source_reg = 5'h00, i_dest_reg = 5'h00;
  logic [5:0] i_disp = 6'h00;
  logic [15:0] i_abs_addr = 16'h0000, o_dmem_addr, o_pmem_addr, o_x, o_y, o_z, o_sp;
  logic [7:0] i_sreg_in = 8'h5A, o_dmem_wdata, i_dmem_rdata, i_pmem_rdata, o_sreg;
  logic o_dmem_we, o_dmem_re, o_pmem_re, o_busy, o_done;
  int num_errors = 0;
  int checked = 0;
  always #50 i_clk = ~i_clk;
  ssx_exec i_ssx_exec (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_start(i_start),
    .i_op(i_op), .i_ptr_sel(i_ptr_sel), .i_source_reg(i_source_reg), .i_dest_reg(i_dest_reg),
    .i_disp(i_disp), .i_abs_addr(i_abs_addr), .i_sreg_in(i_sreg_in), .o_dmem_addr(o_dmem_addr),
    .o_dmem_wdata(o_dmem_wdata), .o_dmem_we(o_dmem_we), .o_dmem_re(o_dmem_re),
    .i_dmem_rdata(i_dmem_rdata), .o_pmem_addr(o_pmem_addr), .o_pmem_re(o_pmem_re),
    .i_pmem_rdata(i_pmem_rdata), .o_busy(o_busy), .o_done(o_done), .o_x(o_x), .o_y(o_y),
    .o_z(o_z), .o_sp(o_sp), .o_sreg(o_sreg));
  ssx_mem_model i_ssx_mem_model (.i_clk(i_clk), .i_dmem_we(o_dmem_we), .i_dmem_re(o_dmem_re),
    .i_pmem_re(o_pmem_re), .i_dmem_addr(o_dmem_addr), .i_pmem_addr(o_pmem_addr),
    .i_dmem_wdata(o_dmem_wdata), .o_dmem_rdata(i_dmem_rdata), .o_pmem_rdata(i_pmem_rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Flags are moved during the run, so a held value proves the core left them alone.
  task automatic run(input ssx_op_e op, input logic [1:0] ptr, input logic [4:0] src,
                     input logic [4:0] dst, input logic [15:0] n_exp);
    logic [15:0] n;
    logic seen;
    n = 16'h0000;
    seen = 1'b0;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op <= op;
    i_ptr_sel <= ptr;
    i_source_reg <= src;
    i_dest_reg <= dst;
    @(posedge i_clk);
    i_start <= 1'b0;
    i_sreg_in <= 8'hC3;
    #1;
    // Busy spans the whole instruction, and done must mark its last cycle.
    while (o_busy === 1'b1 && n < 16'h0008) begin
      n++;
      seen = o_done;
      @(posedge i_clk);
      #1;
    end
    chk(n, n_exp, "busy cycles");
    chk({15'h0000, seen}, 16'h0001, "done in last cycle");
    chk({8'h00, o_sreg}, 16'h005A, "flags");
    @(posedge i_clk);
    i_sreg_in <= 8'h5A;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    chk(i_ssx_mem_model.last_addr, a, "write address");
    chk({8'h00, i_ssx_mem_model.last_data}, d, "write data");
  endtask
  task automatic t_stack;
    run(SSX_OP_POP, 2'h0, 5'h00, 5'h05, 16'h0002);
    chk(o_sp, 16'h0300, "sp after pop");
    run(SSX_OP_PUSH, 2'h0, 5'h05, 5'h00, 16'h0002);
    wr(16'h0300, 16'h00A5);
    chk(o_sp, SSX_SP_RST, "sp after push");
    $display("test stack done");
  endtask
  task automatic t_indirect;
    run(SSX_OP_CODE_INC, 2'h2, 5'h00, 5'h06, 16'h0003);
    chk(o_z, 16'h0001, "z after code read");
    run(SSX_OP_WR_POST, 2'h0, 5'h06, 5'h00, 16'h0002);
    wr(16'h0000, 16'h00FF);
    chk(o_x, 16'h0001, "x after post inc");
    run(SSX_OP_WR_PRE, 2'h1, 5'h06, 5'h00, 16'h0002);
    wr(16'hFFFF, 16'h00FF);
    chk(o_y, 16'hFFFF, "y after pre dec");
    run(SSX_OP_WR_PLAIN, 2'h0, 5'h05, 5'h00, 16'h0002);
    wr(16'h0001, 16'h00A5);
    chk(o_x, 16'h0001, "x after plain store");
    $display("test indirect done");
  endtask
  task automatic t_offset_abs;
    @(posedge i_clk);
    i_disp <= 6'h3F;
    i_abs_addr <= 16'h1234;
    run(SSX_OP_WR_OFS, 2'h2, 5'h05, 5'h00, 16'h0002);
    wr(16'h0040, 16'h00A5);
    chk(o_z, 16'h0001, "z after offset");
    run(SSX_OP_WR_ABS, 2'h0, 5'h06, 5'h00, 16'h0002);
    wr(16'h1234, 16'h00FF);
    run(SSX_OP_CODE_RD, 2'h2, 5'h00, SSX_IDX_RES_LOW, 16'h0003);
    chk(o_z, 16'h0001, "z after plain read");
    run(SSX_OP_PUSH, 2'h0, SSX_IDX_RES_LOW, 5'h00, 16'h0002);
    wr(16'h02FF, 16'h00FE);
    chk(o_sp, 16'h02FE, "sp after push");
    $display("test offset and absolute done");
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk(o_sp, SSX_SP_RST, "sp reset");
    t_stack();
    t_indirect();
    t_offset_abs();
    report_and_stop();
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb
